// ==== uat_pkg.sv ====
/*
 * Package for the asynchronous serial transmitter: constants and carrier types.
 * Assumes it is compiled before every file that names it.
 */
package uat_pkg;

	// ==========================================================
	// Reset values and frame layout
	// ==========================================================
	localparam logic       POLARITY_RST  = 1'h0;
	localparam logic       ENABLE_RST    = 1'h0;
	localparam logic [3:0] DATA_BITS_8   = 4'h8;
	localparam logic [3:0] DATA_BITS_9   = 4'h9;
	localparam logic [3:0] BIT_CNT_RST   = 4'h0;
	localparam logic [8:0] SHIFT_RST     = 9'h1FF;
	localparam logic       MARK_LEVEL    = 1'h1;
	localparam logic       SPACE_LEVEL   = 1'h0;
	localparam logic [1:0] FLAG_DLY_RST  = 2'h0;
	localparam logic [1:0] FLAG_DLY_CYC  = 2'h2;

	// ==========================================================
	// Types
	// ==========================================================
	typedef struct packed {
		logic       ninth;
		logic [7:0] low;
	} uat_char_t;

	typedef struct packed {
		logic serial_port_enable_bit;
		logic transmit_enable_bit;
		logic sync_mode;
		logic nine_bit_select;
		logic polarity_select_bit;
	} uat_cfg_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_START,
		ST_DATA,
		ST_STOP
	} uat_state_t;

endpackage

// ==== uat_buf2.sv ====
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/10ps
module uat_buf2 (
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic              in_valid,
	output logic                   in_ready,
	input  wire uat_pkg::uat_char_t in_data,
	output logic                   out_valid,
	input  wire logic              out_ready,
	output uat_pkg::uat_char_t     out_data,
	output logic [1:0]             fill
);

	// ==========================================================
	// Storage
	// ==========================================================
	uat_pkg::uat_char_t mem_r [2];
	logic               wr_ptr_r;
	logic               rd_ptr_r;
	logic [1:0]         cnt_r;
	wire                push;
	wire                pop;

	// Handshakes; full and empty follow the entry count honestly.
	assign in_ready  = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem_r[rd_ptr_r];
	assign fill      = cnt_r;

	// Pointer and count update.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_r <= 1'h0;
			rd_ptr_r <= 1'h0;
			cnt_r    <= 2'h0;
		end else begin
			wr_ptr_r <= wr_ptr_r ^ push;
			rd_ptr_r <= rd_ptr_r ^ pop;
			cnt_r    <= 2'(cnt_r + {1'h0, push} - {1'h0, pop});
		end
	end

	// Entry writes need no reset since valid is tracked by the count.
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

endmodule

// ==== uat_tx.sv ====
/*
 * Asynchronous serial transmitter: holding buffer, hidden shift register,
 * NRZ framing, polarity select and buffer-empty status.
 * Assumes a single-cycle baud tick from a shared baud generator on ref_clk,
 * and configuration bits from logic on the same clock.
 */
`timescale 1ns/10ps
module uat_tx (
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire uat_pkg::uat_cfg_t cfg,
	input  wire logic              baud_tick,
	input  wire logic              ninth_data_bit,
	input  wire logic [7:0]        wr_data,
	input  wire logic              wr_valid,
	output logic                   wr_ready,
	input  wire logic              tx_buffer_empty_irq_enable,
	output logic                   tx_buffer_empty_flag,
	output logic                   tx_irq_request,
	output logic                   shift_register_empty_status,
	output logic                   transmit_clock_pin_out,
	output logic                   transmit_clock_pin_oe,
	output logic                   configurable_logic_cell_tx
);

	// ==========================================================
	// Configuration decode
	// ==========================================================
	wire async_on;
	wire tx_on;
	wire [3:0] data_len;

	// Transmitter runs only when port enabled, tx enabled and sync clear.
	assign async_on = cfg.serial_port_enable_bit & ~cfg.sync_mode;
	assign tx_on    = async_on & cfg.transmit_enable_bit;
	assign data_len = cfg.nine_bit_select ? uat_pkg::DATA_BITS_9
	                                      : uat_pkg::DATA_BITS_8;

	// ==========================================================
	// Holding buffer
	// ==========================================================
	uat_pkg::uat_char_t wr_char;
	uat_pkg::uat_char_t hold_char;
	logic               hold_valid;
	logic               hold_ready;
	logic               buf_in_ready;
	logic [1:0]         buf_fill;

	// The ninth bit is sampled with the low byte in the same write.
	assign wr_char  = '{ninth: ninth_data_bit, low: wr_data};
	assign wr_ready = buf_in_ready & tx_on;

	// Two entries keep a stalled shifter from losing a word; the writer
	// sees wr_ready drop when both are occupied.
	uat_buf2 u_hold (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.in_valid  (wr_valid & tx_on),
		.in_ready  (buf_in_ready),
		.in_data   (wr_char),
		.out_valid (hold_valid),
		.out_ready (hold_ready),
		.out_data  (hold_char),
		.fill      (buf_fill)
	);

	// ==========================================================
	// Shift register and frame sequencer
	// ==========================================================
	uat_pkg::uat_state_t state_r;
	uat_pkg::uat_state_t state_nxt;
	logic [8:0]          shift_r;
	logic [8:0]          shift_nxt;
	logic [3:0]          bit_cnt_r;
	logic [3:0]          bit_cnt_nxt;
	logic                line_r;
	logic                line_nxt;
	wire                 load;
	wire                 last_data;

	// A character loads whenever the shifter is idle and tx_on is set, which includes the
	// cycle right after the stop bit ends.
	assign load       = (state_r == uat_pkg::ST_IDLE) & hold_valid & tx_on;
	assign hold_ready = load;
	assign last_data  = (bit_cnt_r == 4'(data_len - 4'h1));

	// Next-state logic; every bit advances only on a baud tick.
	always_comb begin
		state_nxt   = state_r;
		shift_nxt   = shift_r;
		bit_cnt_nxt = bit_cnt_r;
		line_nxt    = line_r;
		case (state_r)
			uat_pkg::ST_IDLE: begin
				line_nxt = uat_pkg::MARK_LEVEL;
				if (load) begin
					// Ninth bit rides above the byte so it leaves last.
					shift_nxt   = {hold_char.ninth, hold_char.low};
					bit_cnt_nxt = uat_pkg::BIT_CNT_RST;
					state_nxt   = uat_pkg::ST_START;
				end
			end
			uat_pkg::ST_START: begin
				if (baud_tick) begin
					line_nxt  = uat_pkg::SPACE_LEVEL;
					state_nxt = uat_pkg::ST_DATA;
				end
			end
			uat_pkg::ST_DATA: begin
				if (baud_tick) begin
					line_nxt    = shift_r[0];
					shift_nxt   = {uat_pkg::MARK_LEVEL, shift_r[8:1]};
					bit_cnt_nxt = 4'(bit_cnt_r + 4'h1);
					if (last_data) begin
						state_nxt = uat_pkg::ST_STOP;
					end
				end
			end
			uat_pkg::ST_STOP: begin
				if (baud_tick) begin
					if (bit_cnt_r != uat_pkg::BIT_CNT_RST) begin
						// Drive the stop bit for a full period.
						line_nxt    = uat_pkg::MARK_LEVEL;
						bit_cnt_nxt = uat_pkg::BIT_CNT_RST;
					end else begin
						state_nxt = uat_pkg::ST_IDLE;
					end
				end
			end
			default: begin
				state_nxt = uat_pkg::ST_IDLE;
			end
		endcase
		if (!tx_on) begin
			state_nxt = uat_pkg::ST_IDLE;
			line_nxt  = uat_pkg::MARK_LEVEL;
		end
	end

	// Sequencer registers.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r   <= uat_pkg::ST_IDLE;
			shift_r   <= uat_pkg::SHIFT_RST;
			bit_cnt_r <= uat_pkg::BIT_CNT_RST;
			line_r    <= uat_pkg::MARK_LEVEL;
		end else begin
			state_r   <= state_nxt;
			shift_r   <= shift_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			line_r    <= line_nxt;
		end
	end

	// ==========================================================
	// Status flags
	// ==========================================================
	logic       flag_r;
	logic       flag_nxt;
	logic       tsr_empty_r;
	wire        flag_raw;
	wire        write_seen;

	// Empty while tx_on unless the shifter is busy and another char waits; with the
	// two-entry buffer a waiting char means the buffer holds any entry
	// while busy, not only when the buffer is full.
	assign flag_raw   = tx_on & ~(hold_valid & (state_r != uat_pkg::ST_IDLE));
	assign write_seen = wr_valid & wr_ready;

	// The flag keeps its old value across the write edge and follows buffer
	// state from the next edge on, so a poll right after the write reads stale.
	assign flag_nxt = (write_seen & tx_on) ? flag_r : flag_raw;

	// Flag pipeline; no software path reaches these flip-flops.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_r      <= uat_pkg::ENABLE_RST;
			tsr_empty_r <= 1'h1;
		end else begin
			flag_r      <= flag_nxt;
			tsr_empty_r <= (state_nxt == uat_pkg::ST_IDLE);
		end
	end

	// The enable gates only the request, never the flag itself.
	assign tx_buffer_empty_flag        = flag_r;
	assign tx_irq_request              = flag_r & tx_buffer_empty_irq_enable;
	assign shift_register_empty_status = tsr_empty_r;

	// ==========================================================
	// Output polarity and pin
	// ==========================================================
	wire line_out;

	// Inversion applies only in async mode; sync mode owns the bit otherwise.
	assign line_out = line_r ^ (cfg.polarity_select_bit & async_on);

	// The port enable alone turns the pin driver on.
	assign transmit_clock_pin_out     = line_out;
	assign transmit_clock_pin_oe      = cfg.serial_port_enable_bit;
	assign configurable_logic_cell_tx = line_out;

endmodule

// ==== uat_tx_sva.sv ====
/* Port checker for the serial transmitter.
   Assumes it is bound to uat_tx and sees one clock domain. */
`timescale 1ns/10ps
module uat_tx_sva (
	input wire logic              ref_clk,
	input wire logic              rst_n,
	input wire uat_pkg::uat_cfg_t cfg,
	input wire logic              baud_tick,
	input wire logic              wr_valid,
	input wire logic              wr_ready,
	input wire logic              tx_buffer_empty_irq_enable,
	input wire logic              tx_buffer_empty_flag,
	input wire logic              tx_irq_request,
	input wire logic              shift_register_empty_status,
	input wire logic              transmit_clock_pin_out,
	input wire logic              transmit_clock_pin_oe,
	input wire logic              configurable_logic_cell_tx
);
	logic              tx_on;
	logic              pol;
	uat_pkg::uat_cfg_t cfg_q1_r;
	uat_pkg::uat_cfg_t cfg_q2_r;
	// ==========================================================
	// Helpers
	// ==========================================================
	// A config change may legally move the line, so two quiet cycles are demanded.
	assign tx_on = cfg.serial_port_enable_bit & cfg.transmit_enable_bit & ~cfg.sync_mode;
	assign pol   = cfg.polarity_select_bit & cfg.serial_port_enable_bit & ~cfg.sync_mode;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q1_r <= '0;
			cfg_q2_r <= '0;
		end else begin
			cfg_q1_r <= cfg;
			cfg_q2_r <= cfg_q1_r;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Properties
	// ==========================================================
	a_pin_enable: assert property (transmit_clock_pin_oe == cfg.serial_port_enable_bit)
		else $error("pin enable wrong");
	a_cell_copy: assert property (configurable_logic_cell_tx == transmit_clock_pin_out)
		else $error("cell copy differs");
	a_irq_gate: assert property (tx_irq_request == (tx_buffer_empty_flag && tx_buffer_empty_irq_enable))
		else $error("irq gate wrong");
	a_idle_mark: assert property (shift_register_empty_status && cfg == cfg_q1_r
		|-> transmit_clock_pin_out == (uat_pkg::MARK_LEVEL ^ pol))
		else $error("idle not mark");
	a_bit_edges: assert property ($changed(transmit_clock_pin_out) && cfg == cfg_q1_r
		&& cfg_q1_r == cfg_q2_r |-> $past(baud_tick))
		else $error("line moved off tick");
	a_enable_flag: assert property ($rose(tx_on) |-> ##[1:2] tx_buffer_empty_flag)
		else $error("flag not set");
	a_queued_flag: assert property ((wr_valid && wr_ready && !shift_register_empty_status)
		##1 (!shift_register_empty_status)[*2] |-> !tx_buffer_empty_flag)
		else $error("flag not cleared");
	a_flag_stands: assert property ((wr_valid && wr_ready && tx_buffer_empty_flag) ##1 tx_on
		|-> tx_buffer_empty_flag)
		else $error("flag fell early");
	a_off_refuse: assert property (!tx_on |-> !wr_ready)
		else $error("ready while off");
	a_load_busy: assert property (shift_register_empty_status && wr_valid && wr_ready
		|-> ##[1:2] !shift_register_empty_status)
		else $error("no load");
endmodule
bind uat_tx uat_tx_sva u_sva (.ref_clk(ref_clk), .rst_n(rst_n), .cfg(cfg),
	.baud_tick(baud_tick), .wr_valid(wr_valid), .wr_ready(wr_ready),
	.tx_buffer_empty_irq_enable(tx_buffer_empty_irq_enable),
	.tx_buffer_empty_flag(tx_buffer_empty_flag), .tx_irq_request(tx_irq_request),
	.shift_register_empty_status(shift_register_empty_status),
	.transmit_clock_pin_out(transmit_clock_pin_out),
	.transmit_clock_pin_oe(transmit_clock_pin_oe),
	.configurable_logic_cell_tx(configurable_logic_cell_tx));

// ==== uat_rx_model.sv ====
/* Receiver model on the serial line.
   Assumes the line is handed over in high-true polarity. */
`timescale 1ns/10ps
module uat_rx_model (
	input wire logic   ref_clk,
	input wire logic   rst_n,
	input wire logic   baud_tick,
	input wire logic   line,
	input wire logic   nine,
	output logic       got,
	output logic [9:0] frame
);
	logic       busy_r;
	logic [3:0] cnt_r;
	logic [8:0] sh_r;
	logic [3:0] nbits;
	// ==========================================================
	// Sampling
	// ==========================================================
	// Each bit is read at the tick closing it, so a short or late bit is misread.
	assign nbits = nine ? uat_pkg::DATA_BITS_9 : uat_pkg::DATA_BITS_8;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_r <= 1'b0;
			got    <= 1'b0;
			cnt_r  <= 4'h0;
			sh_r   <= 9'h000;
			frame  <= 10'h000;
		end else begin
			got <= 1'b0;
			if (baud_tick && !busy_r && line == uat_pkg::SPACE_LEVEL) begin
				busy_r <= 1'b1;
				cnt_r  <= 4'h0;
				sh_r   <= 9'h000;
			end else if (baud_tick && busy_r && cnt_r < nbits) begin
				sh_r[cnt_r] <= line;
				cnt_r       <= cnt_r + 4'h1;
			end else if (baud_tick && busy_r) begin
				busy_r <= 1'b0;
				got    <= 1'b1;
				frame  <= {line != uat_pkg::MARK_LEVEL, sh_r};
			end
		end
	end
endmodule

// ==== tb_uart_async_transmitter.sv ====
/* Self-checking bench for the serial transmitter.
   Assumes uat_tx, the receiver model and the checker are compiled first. */
`timescale 1ns/10ps
module tb_uart_async_transmitter;
	localparam int     BAUD = 4;
	logic              ref_clk, rst_n, baud_tick, ninth_data_bit, wr_valid, irq_en;
	logic              wr_ready, flag, irq, sre, pin, oe, configurable_logic_cell, got;
	logic [7:0]        wr_data;
	logic [9:0]        frame;
	uat_pkg::uat_cfg_t cfg;
	logic [9:0]        rx_q[$];
	int                bcnt, cycles, fails, check_count;
	// ==========================================================
	// Clock, baud tick, receiver queue and timeout
	// ==========================================================
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		bcnt      <= (bcnt == BAUD - 1) ? 0 : bcnt + 1;
		baud_tick <= (bcnt == BAUD - 1);
		cycles    <= cycles + 1;
		if (got) rx_q.push_back(frame);
		if (cycles == 5000) begin
			fails++;
			final_report();
		end
	end
	uat_tx DUT (.ref_clk(ref_clk), .rst_n(rst_n), .cfg(cfg), .baud_tick(baud_tick),
		.ninth_data_bit(ninth_data_bit), .wr_data(wr_data), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .tx_buffer_empty_irq_enable(irq_en),
		.tx_buffer_empty_flag(flag), .tx_irq_request(irq),
		.shift_register_empty_status(sre), .transmit_clock_pin_out(pin),
		.transmit_clock_pin_oe(oe), .configurable_logic_cell_tx(configurable_logic_cell));
	uat_rx_model u_rx (.ref_clk(ref_clk), .rst_n(rst_n), .baud_tick(baud_tick),
		.line(pin ^ (cfg.polarity_select_bit & ~cfg.sync_mode)),
		.nine(cfg.nine_bit_select), .got(got), .frame(frame));
	// ==========================================================
	// Shared tasks
	// ==========================================================
	task automatic chk(input logic [9:0] a, input logic [9:0] e, input string m);
		check_count++;
		if (a !== e) begin
			fails++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	// The request is held until the edge that takes it; the caller releases it.
	task automatic send(input logic [8:0] c);
		int n;
		n = 0;
		ninth_data_bit <= c[8];
		wr_data        <= c[7:0];
		wr_valid       <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (!wr_ready && n < 500);
		if (!wr_ready) chk(10'h000, 10'h001, "write refused");
	endtask
	task automatic rx_exp(input logic [8:0] c);
		int n;
		n = 0;
		while (rx_q.size() == 0 && n < 2000) begin
			@(posedge ref_clk);
			n++;
		end
		if (rx_q.size() == 0) chk(10'h000, 10'h001, "no frame");
		else chk(rx_q.pop_front(), {1'b0, c}, "frame");
	endtask
	task automatic final_report();
		if (fails == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		{rst_n, baud_tick, ninth_data_bit, wr_valid, irq_en} = 5'h00;
		{bcnt, cycles, fails, check_count} = '0;
		cfg     = '0;
		wr_data = 8'h00;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		chk({sre, flag, pin, oe, wr_ready}, 10'h014, "reset state");
		cfg.serial_port_enable_bit <= 1'b1;
		cfg.transmit_enable_bit    <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk({flag, oe, irq}, 10'h006, "enable");
		irq_en <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk(irq, 10'h001, "irq");
		send(9'h0A5);
		send(9'h001);
		wr_valid <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk({flag, sre}, 10'h000, "queued");
		send(9'h0FE);
		wr_valid <= 1'b0;
		rx_exp(9'h0A5);
		rx_exp(9'h001);
		rx_exp(9'h0FE);
		repeat (2 * BAUD) @(posedge ref_clk);
		chk({flag, sre}, 10'h003, "drained");
		cfg.nine_bit_select <= 1'b1;
		send(9'h13C);
		send(9'h0C3);
		wr_valid <= 1'b0;
		rx_exp(9'h13C);
		rx_exp(9'h0C3);
		cfg.nine_bit_select     <= 1'b0;
		cfg.polarity_select_bit <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk({pin, configurable_logic_cell}, 10'h000, "inverted idle");
		send(9'h05A);
		wr_valid <= 1'b0;
		irq_en   <= 1'b0;
		rx_exp(9'h05A);
		cfg.sync_mode <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk({pin, wr_ready, flag, irq}, 10'h008, "sync mode");
		final_report();
	end
endmodule
